// *** hdl/fxd_pkg.sv ***
// Package with the constants, field layout and carrier types of the FP exception unit
package fxd_pkg;

    // ************************************************************
    // Widths and field positions
    // ************************************************************
    localparam int FXD_DW = 64;
    localparam int FXD_FLAGS = 6;
    localparam int FXD_ADDR_W = 4;
    localparam int FXD_BIT_INV = 0;
    localparam int FXD_BIT_DZE = 1;
    localparam int FXD_BIT_OVF = 2;
    localparam int FXD_BIT_UNF = 3;
    localparam int FXD_BIT_INE = 4;
    localparam int FXD_BIT_IOV = 5;

    // ************************************************************
    // Register offsets and reset values
    // ************************************************************
    localparam logic [FXD_ADDR_W-1:0] FXD_REG_CTRL = 4'h0;
    localparam logic [FXD_ADDR_W-1:0] FXD_REG_STAT = 4'h1;
    localparam logic [FXD_FLAGS-1:0] FXD_FLAGS_RST = 6'h00;
    localparam logic [FXD_DW-1:0] FXD_ZERO64 = 64'h0000_0000_0000_0000;
    localparam logic [31:0] FXD_ZERO32 = 32'h0000_0000;
    localparam logic [FXD_DW-1:0] FXD_RDATA_RST = 64'h0000_0000_0000_0000;

    // ************************************************************
    // Operation classes
    // ************************************************************
    typedef enum logic [2:0] {
        FXD_OP_ARITH = 3'b000,
        FXD_OP_DIV = 3'b001,
        FXD_OP_SIGNCOPY = 3'b010,
        FXD_OP_FTOQ = 3'b011,
        FXD_OP_QTOL = 3'b100
    } fxd_op_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        fxd_op_t op;
        logic ieee;
        logic can_except;
        logic dest_float;
        logic opnd_nonfinite;
        logic num_valid;
        logic num_zero;
        logic den_zero;
        logic res_too_big;
        logic res_too_small;
        logic res_inexact;
        logic res_integral;
        logic int_out_of_range;
        logic en_unf;
        logic en_ine;
        logic en_iov;
        logic sw_completion_ind;
        logic [FXD_DW-1:0] result;
    } fxd_req_t;

    typedef struct packed {
        logic valid;
        logic trap;
        logic sw_completion_ind;
        logic dest_undef;
        logic [FXD_FLAGS-1:0] exc;
        logic [FXD_DW-1:0] result;
    } fxd_rpt_t;

    typedef struct packed {
        logic [FXD_FLAGS-1:0] flags;
        fxd_rpt_t rpt;
        logic [FXD_DW-1:0] rdata;
    } fxd_state_t;

endpackage : fxd_pkg

// *** hdl/fxd_unit.sv ***
// FP exception detection, sticky flag register and trap report to the issue unit
//
// How it works
// RL1 - Invalid op always traps, sets flag, undefined dest
// RL2 - Legacy reserved or dirty-zero operand raises invalid
// RL3 - IEEE NaN, infinity, denormal operand raises invalid
// RL4 - IEEE zero over zero: invalid, not divide-zero
// RL5 - Divide-by-zero always traps, sets flag
// RL6 - Legacy: valid numerator, zero denominator is divzero
// RL7 - IEEE: valid nonzero numerator, zero denominator
// RL8 - Overflow always traps, sets flag, undefined dest
// RL9 - Overflow only for floating destinations
// RL10 - Underflow writes all-zero 64-bit result
// RL11 - Underflow flag always; trap only if enabled
// RL12 - Would-be denormals become underflow
// RL13 - Rounded result written whatever inexact enable
// RL14 - Inexact sets flag; traps only if enabled
// RL15 - Enabled inexact accompanies overflow and underflow
// RL16 - Inexact accompanies integer overflow too
// RL17 - Quad-to-long overflow sets inexact, never traps it
// RL18 - Integer overflow keeps low 64/32 bits
// RL19 - Float-to-quad overflow outside signed 64 range
// RL20 - Quad-to-long overflow outside signed 32 range
// RL21 - Completion indication forwarded, never stored
// RL22 - Input exceptions suppress output exceptions
// RL23 - Flags sticky until software writes them clear
//
// The register addresses and strobed register access are this design's own decisions.
module fxd_unit
    import fxd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Classified instruction from the FP pipe
    input wire fxd_req_t req,
    // Report to the issue and trap unit
    output fxd_rpt_t rpt,
    // Register port
    input wire logic [FXD_ADDR_W-1:0] reg_addr,
    input wire logic [FXD_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [FXD_DW-1:0] reg_rdata
);

    fxd_state_t st;
    fxd_state_t next_st;

    // ************************************************************
    // Detection
    // ************************************************************
    logic is_div;
    logic is_int;
    logic in_inv;
    logic in_dze;
    logic input_exc;
    logic out_ovf;
    logic out_unf;
    logic out_iov;
    logic out_ine;
    logic raw_ine;
    logic [FXD_FLAGS-1:0] exc;
    logic trap;
    logic [FXD_FLAGS-1:0] clr_mask;

    always_comb begin
        is_div = (req.op == FXD_OP_DIV);
        is_int = (req.op == FXD_OP_FTOQ) || (req.op == FXD_OP_QTOL);
        // Sign-copy never raises invalid, whatever the operands
        in_inv = req.can_except && (req.op != FXD_OP_SIGNCOPY) && req.opnd_nonfinite; // [RL2] [RL3]
        if (is_div && req.ieee && req.num_zero && req.den_zero) begin
            in_inv = 1'b1; // [RL4]
        end
        if (req.ieee) begin
            in_dze = is_div && req.num_valid && !req.num_zero && req.den_zero; // [RL7] [RL4]
        end else begin
            in_dze = is_div && req.num_valid && req.den_zero; // [RL6]
        end
        in_dze = in_dze && !in_inv;
        input_exc = in_inv || in_dze;
        // Result-side checks; too_small also covers would-be denormals
        out_ovf = !input_exc && req.dest_float && req.res_too_big; // [RL8] [RL9]
        out_unf = !input_exc && req.dest_float && req.res_too_small; // [RL11] [RL12]
        out_iov = !input_exc && is_int && req.int_out_of_range; // [RL18] [RL19] [RL20] [RL22]
        raw_ine = req.res_inexact && (!is_int || req.res_integral); // [RL14]
        out_ine = !input_exc && (raw_ine || out_iov
                  || (req.en_ine && (out_ovf || out_unf))); // [RL15] [RL16] [RL17]
        exc = '0;
        exc[FXD_BIT_INV] = in_inv;
        exc[FXD_BIT_DZE] = in_dze;
        exc[FXD_BIT_OVF] = out_ovf;
        exc[FXD_BIT_UNF] = out_unf;
        exc[FXD_BIT_INE] = out_ine;
        exc[FXD_BIT_IOV] = out_iov;
        if (!req.valid) begin
            exc = '0;
        end
        trap = exc[FXD_BIT_INV] || exc[FXD_BIT_DZE] || exc[FXD_BIT_OVF] // [RL1] [RL5] [RL8]
               || (exc[FXD_BIT_UNF] && req.en_unf) // [RL11]
               || (exc[FXD_BIT_IOV] && req.en_iov)
               || (exc[FXD_BIT_INE] && req.en_ine
                   && (req.op != FXD_OP_QTOL)); // [RL14] [RL17]
    end

    // ************************************************************
    // State update
    // ************************************************************
    always_comb begin
        next_st = st;
        clr_mask = '0;
        if (reg_wr && (reg_addr == FXD_REG_STAT)) begin
            // Write one to clear a sticky flag
            clr_mask = reg_wdata[FXD_FLAGS-1:0];
        end
        next_st.flags = (st.flags & ~clr_mask) | exc; // [RL23]
        next_st.rpt.valid = req.valid;
        next_st.rpt.trap = trap;
        next_st.rpt.sw_completion_ind = req.valid && req.sw_completion_ind; // [RL21]
        next_st.rpt.exc = exc;
        next_st.rpt.dest_undef = exc[FXD_BIT_INV] || exc[FXD_BIT_DZE]
                                 || exc[FXD_BIT_OVF]; // [RL1] [RL5] [RL8]
        if (exc[FXD_BIT_UNF]) begin
            next_st.rpt.result = FXD_ZERO64; // [RL10]
        end else if (req.op == FXD_OP_QTOL) begin
            next_st.rpt.result = {FXD_ZERO32, req.result[31:0]}; // [RL18]
        end else begin
            next_st.rpt.result = req.result; // [RL13] [RL18]
        end
        next_st.rdata = FXD_RDATA_RST;
        if (reg_rd && (reg_addr == FXD_REG_STAT)) begin
            next_st.rdata[FXD_FLAGS-1:0] = st.flags;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st.flags <= FXD_FLAGS_RST;
            st.rpt <= '0;
            st.rdata <= FXD_RDATA_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rpt = st.rpt;
    assign reg_rdata = st.rdata;

endmodule // fxd_unit

// *** dv/fxd_issue_model.sv ***
// Issue unit stand-in that keeps the completion summary bit
module fxd_issue_model
    import fxd_pkg::*;
(
    // Clock, reset and report
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire fxd_rpt_t rpt,
    // Summary
    output logic sum_swc
);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sum_swc <= 1'b0;
        end else if (rpt.valid && rpt.sw_completion_ind && |rpt.exc) begin
            sum_swc <= 1'b1;
        end
    end
endmodule // fxd_issue_model

// *** dv/fxd_chk_properties.sv ***
// Port checker for the FP exception unit
module fxd_chk
    import fxd_pkg::*;
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire fxd_req_t req,
    input wire fxd_rpt_t rpt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic c;
    assign c = req.valid && req.can_except;
    property p_inv; c && req.opnd_nonfinite |=> rpt.exc[0] && rpt.trap && rpt.dest_undef; endproperty
    a_inv: assert property (p_inv) else $error("inv");
    property p_pri; c && req.opnd_nonfinite |=> rpt.exc[3:2] == 2'h0; endproperty
    a_pri: assert property (p_pri) else $error("prio");
    property p_zz; c && req.op == FXD_OP_DIV && req.ieee && req.num_zero && req.den_zero
        |=> rpt.exc[1:0] == 2'h1; endproperty
    a_zz: assert property (p_zz) else $error("zz");
    property p_ovf; req.valid && !req.dest_float |=> !rpt.exc[2]; endproperty
    a_ovf: assert property (p_ovf) else $error("ovf");
    property p_unf; c && req.dest_float && req.res_too_small && !req.opnd_nonfinite
        |=> rpt.exc[3] && rpt.result == FXD_ZERO64; endproperty
    a_unf: assert property (p_unf) else $error("unf");
    property p_ine; c && req.dest_float && req.res_too_big && req.en_ine && !req.opnd_nonfinite
        |=> rpt.exc[4] && rpt.exc[2] && rpt.trap; endproperty
    a_ine: assert property (p_ine) else $error("ine");
    property p_swc; req.valid |=> rpt.valid && rpt.sw_completion_ind == $past(req.sw_completion_ind); endproperty
    a_swc: assert property (p_swc) else $error("swc");
    property p_qtl; c && req.op == FXD_OP_QTOL && req.int_out_of_range && !req.en_iov
        |=> rpt.exc[5:4] == 2'h3 && !rpt.trap && rpt.result == {FXD_ZERO32, $past(req.result[31:0])};
    endproperty
    a_qtl: assert property (p_qtl) else $error("qtl");
endmodule // fxd_chk
bind fxd_unit fxd_chk u_chk(.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .rpt(rpt));

// *** dv/tb_top.sv ***
// Self-checking bench for the FP exception unit
module tb_top
    import fxd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, sum_swc;
    logic [FXD_ADDR_W-1:0] reg_addr = '0;
    logic [FXD_DW-1:0] reg_wdata = '0, reg_rdata;
    fxd_req_t req = '0, q;
    fxd_rpt_t rpt;
    int n_errors = 0, compares = 0;
    fxd_unit u_dut(.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .rpt(rpt), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    fxd_issue_model u_iss(.sys_clk(sys_clk), .arst_n(arst_n), .rpt(rpt), .sum_swc(sum_swc));
    initial forever #5 sys_clk = ~sys_clk;
    task chk(input logic [63:0] g, input logic [63:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task send(input fxd_req_t r, input logic [7:0] e);
        @(posedge sys_clk) req <= r;
        @(posedge sys_clk) req <= '0;
        #1 chk({rpt.trap, rpt.dest_undef, rpt.exc}, e);
    endtask
    task rd(input logic [3:0] a, input logic [63:0] e);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task t_div;
        q = '0; {q.valid, q.op, q.ieee, q.can_except, q.num_valid} = {1'b1, FXD_OP_DIV, 3'h7};
        q.den_zero = 1;
        send(q, 8'hc2);
        q.num_zero = 1;
        send(q, 8'hc1);
        q.ieee = 0;
        send(q, 8'hc2);
        send('0, 8'h00);
        rd(FXD_REG_STAT, 64'h03);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {FXD_REG_STAT, 64'h03, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
        rd(FXD_REG_STAT, 64'h00);
        rd(4'h5, 64'h00);
    endtask
    task t_res;
        q = '0; {q.valid, q.ieee, q.can_except, q.dest_float, q.res_inexact} = 5'h1f;
        q.result = 64'h8000_0000_0000_0000; q.res_too_small = 1;
        send(q, 8'h18);
        chk(rpt.result, 64'h0);
        {q.en_unf, q.en_ine} = 2'h3;
        send(q, 8'h98);
        {q.res_too_small, q.res_too_big} = 2'h1;
        send(q, 8'hd4);
        {q.res_too_big, q.en_ine} = 2'h0;
        send(q, 8'h10);
        chk(rpt.result, q.result);
    endtask
    task t_int;
        q = '0; {q.valid, q.op, q.can_except, q.int_out_of_range} = {1'b1, FXD_OP_QTOL, 2'h3};
        q.result = 64'hffff_0001_8000_0000;
        send(q, 8'h30);
        chk(rpt.result, 64'h8000_0000);
        {q.op, q.en_iov, q.res_too_big} = {FXD_OP_FTOQ, 2'h3};
        send(q, 8'hb0);
        q = '0; {q.valid, q.can_except, q.dest_float, q.opnd_nonfinite, q.res_too_big} = 5'h1f;
        q.sw_completion_ind = 1;
        send(q, 8'hc1);
        @(posedge sys_clk);
        #1 chk(sum_swc, 1);
        {q.op, q.can_except, q.res_too_big} = {FXD_OP_SIGNCOPY, 2'h0};
        send(q, 8'h00);
    endtask
    task wrap_up;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000 n_errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_div();
        t_res();
        t_int();
        wrap_up();
    end
endmodule // tb_top
